// [rtl/byte_fifo.sv]
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign IN_READY = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign OUT_VALID = (wr_q != rd_q);
  assign OUT_DATA = mem_q[rd_q[AW-1:0]];
  assign push = IN_VALID & IN_READY;
  assign pop = OUT_VALID & OUT_READY;

  always_ff @(posedge MCLK) begin
    if (CE && push) begin
      mem_q[wr_q[AW-1:0]] <= IN_DATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (CE) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : byte_fifo

// [rtl/eeprom_pkg.sv]
// Constants, types and helpers for the serial memory slave
package eeprom_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 4096;
  localparam int BYTE_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
  // ----------------------------------------------------------------
  // Select word
  // ----------------------------------------------------------------
  localparam int STRAP_W = 3;
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam logic [3:0] BITS_IN_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // ----------------------------------------------------------------
  // Timing and buffering
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 10;
  localparam int PROG_TIME_US = 3000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = PAGE_BITS + BYTE_W;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} bus_state_t;
  typedef enum logic [1:0] {ROLE_DEV, ROLE_AHI, ROLE_ALO, ROLE_DATA} byte_role_t;

  // Next address with wrap inside the current page
  function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
    page_step = {a[ADDR_W-1:PAGE_BITS], a[PAGE_BITS-1:0] + 5'h01};
  endfunction : page_step
endpackage : eeprom_pkg

// [rtl/i2c_serial_eeprom_slave.sv]
// Two-wire serial memory slave with page buffer and program cycle
`timescale 1ns/100ps
// What this block does
// - SDA fall/rise with SCL high: start/stop
// - SDA changes while SCL high mean start/stop
// - Sample on SCL rise, drive after fall
// - Acknowledge each accepted byte on ninth clock
// - Select word 1010, three straps, direction bit
// - Compare select bits with strap inputs
// - Mismatch: no acknowledge, back to standby
// - 4096 bytes, 12-bit word address
// - Two address bytes, high byte first
// - Byte write programs after stop
// - Program cycle ignores bus, up to 3 ms
// - Page write up to 32 bytes
// - Write address wraps within its page
// - Select acknowledged only after programming ends
// - Address counter keeps last address plus one
// - Read address wraps across whole array
// - Current-address read sends byte at counter
// - Random read via dummy write, repeated start
// - Master acknowledge continues sequential read
// - Standby after power-up, after a stop with no write pending, and after programming ends
// - Write-protect high at stop blocks programming; a program cycle already running completes
module i2c_serial_eeprom_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic WP,
  input wire logic [eeprom_pkg::STRAP_W-1:0] CHIP_SELECT_STRAPS,
  output logic BUSY,
  output logic STANDBY
);
  import eeprom_pkg::*;

  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic [2:0] scl_sy_q;
  logic [2:0] sda_sy_q;
  logic [1:0] wp_sy_q;
  logic [STRAP_W-1:0] strap_m_q;
  logic [STRAP_W-1:0] strap_s_q;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic wp_s;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      wp_sy_q <= 2'h0;
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else if (CE) begin
      scl_sy_q <= {scl_sy_q[1:0], SCL};
      sda_sy_q <= {sda_sy_q[1:0], SDA_I};
      wp_sy_q <= {wp_sy_q[0], WP};
      strap_m_q <= CHIP_SELECT_STRAPS;
      strap_s_q <= strap_m_q;
    end
  end

  assign wp_s = wp_sy_q[1];
  assign scl_rise = scl_sy_q[1] & ~scl_sy_q[2];
  assign scl_fall = ~scl_sy_q[1] & scl_sy_q[2];
  assign start_evt = scl_sy_q[1] & scl_sy_q[2] & ~sda_sy_q[1] & sda_sy_q[2];
  assign stop_evt = scl_sy_q[1] & scl_sy_q[2] & sda_sy_q[1] & ~sda_sy_q[2];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  bus_state_t state_q;
  byte_role_t role_q;
  logic [3:0] bitcnt_q;
  logic [BYTE_W-1:0] sh_q;
  logic [BYTE_W-1:0] tx_q;
  logic rw_q;
  logic mack_q;
  logic sda_oe_n_q;
  logic busy_q;
  logic step_ok;
  logic rx_done;
  logic dev_match;
  logic byte_ok;
  logic load_rd;
  logic data_take;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [ADDR_W-1:0] ctr_q;
  logic [ADDR_W-1:0] wptr_q;
  logic [3:0] addr_hi_q;
  logic [BYTE_W-1:0] mem_q [MEM_BYTES];

  assign step_ok = ~busy_q & ~start_evt & ~stop_evt;
  assign rx_done = step_ok & scl_fall & (state_q == ST_RX) & (bitcnt_q == BITS_IN_BYTE);
  assign dev_match = (sh_q[7:4] == DEV_TYPE_CODE) && (sh_q[3:1] == strap_s_q);
  assign byte_ok = (role_q == ROLE_DEV) ? dev_match :
                   (role_q == ROLE_DATA) ? fifo_in_ready : 1'b1;
  assign data_take = rx_done & (role_q == ROLE_DATA) & fifo_in_ready;
  assign load_rd = step_ok & scl_fall &
                   (((state_q == ST_ACK) & (role_q == ROLE_DEV) & rw_q) |
                    ((state_q == ST_MACK) & mack_q));

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      role_q <= ROLE_DEV;
      bitcnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'hFF;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (CE) begin
      if (busy_q) begin
        state_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
      end else if (start_evt) begin
        state_q <= ST_RX;
        role_q <= ROLE_DEV;
        bitcnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_evt) begin
        state_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            sda_oe_n_q <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise && bitcnt_q != BITS_IN_BYTE) begin
              sh_q <= {sh_q[6:0], sda_sy_q[1]};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (rx_done) begin
              if (byte_ok) begin
                state_q <= ST_ACK;
                sda_oe_n_q <= 1'b0;
                if (role_q == ROLE_DEV) begin
                  rw_q <= sh_q[0];
                end
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt_q <= 4'h0;
              if (load_rd) begin
                state_q <= ST_TX;
                tx_q <= mem_q[ctr_q];
                sda_oe_n_q <= mem_q[ctr_q][7];
              end else begin
                state_q <= ST_RX;
                sda_oe_n_q <= 1'b1;
                role_q <= (role_q == ROLE_DEV) ? ROLE_AHI :
                          (role_q == ROLE_AHI) ? ROLE_ALO : ROLE_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_q == LAST_TX_BIT) begin
                state_q <= ST_MACK;
                mack_q <= 1'b0;
                sda_oe_n_q <= 1'b1;
              end else begin
                bitcnt_q <= bitcnt_q + 4'h1;
                tx_q <= {tx_q[6:0], 1'b1};
                sda_oe_n_q <= tx_q[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_sy_q[1];
            end else if (scl_fall) begin
              bitcnt_q <= 4'h0;
              if (mack_q) begin
                state_q <= ST_TX;
                tx_q <= mem_q[ctr_q];
                sda_oe_n_q <= mem_q[ctr_q][7];
              end else begin
                state_q <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Address counter and write pointer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctr_q <= ADDR_RESET;
      wptr_q <= ADDR_RESET;
      addr_hi_q <= 4'h0;
    end else if (CE) begin
      if (rx_done && role_q == ROLE_AHI) begin
        addr_hi_q <= sh_q[3:0];
      end else if (rx_done && role_q == ROLE_ALO) begin
        wptr_q <= {addr_hi_q, sh_q};
        ctr_q <= {addr_hi_q, sh_q};
      end else if (data_take) begin
        wptr_q <= page_step(wptr_q);
        ctr_q <= page_step(wptr_q);
      end else if (load_rd) begin
        ctr_q <= ctr_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .MCLK(MCLK),
    .RST(RST),
    .CE(CE),
    .IN_VALID(rx_done & (role_q == ROLE_DATA)),
    .IN_READY(fifo_in_ready),
    .IN_DATA({wptr_q[PAGE_BITS-1:0], sh_q}),
    .OUT_VALID(fifo_out_valid),
    .OUT_READY(fifo_out_ready),
    .OUT_DATA(fifo_out_data)
  );

  assign fifo_out_ready = ~busy_q;

  // ----------------------------------------------------------------
  // Page buffer and self-timed program cycle
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] pbuf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_q;
  logic pending_q;
  logic [PCW-1:0] pcnt_q;
  logic [PAGE_BITS-1:0] cidx;

  assign cidx = pcnt_q[PAGE_BITS-1:0];

  always_ff @(posedge MCLK) begin
    if (CE && fifo_out_valid && fifo_out_ready) begin
      pbuf_q[fifo_out_data[FIFO_W-1:BYTE_W]] <= fifo_out_data[BYTE_W-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (CE && busy_q && pcnt_q < PCW'(PAGE_BYTES) && mask_q[cidx]) begin
      mem_q[{wptr_q[ADDR_W-1:PAGE_BITS], cidx}] <= pbuf_q[cidx];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      busy_q <= 1'b0;
      pending_q <= 1'b0;
      mask_q <= '0;
      pcnt_q <= '0;
    end else if (CE) begin
      if (busy_q) begin
        pcnt_q <= pcnt_q + 1'b1;
        if (pcnt_q == PCW'(PROG_CYCLES - 1)) begin
          busy_q <= 1'b0;
          mask_q <= '0;
        end
      end else if (start_evt) begin
        pending_q <= 1'b0;
        mask_q <= '0;
      end else if (stop_evt) begin
        pending_q <= 1'b0;
        if (pending_q && !wp_s) begin
          busy_q <= 1'b1;
          pcnt_q <= '0;
        end else begin
          mask_q <= '0;
        end
      end else begin
        if (data_take) begin
          pending_q <= 1'b1;
        end
      end
      // Byte mark wins over a same-cycle clear
      if (fifo_out_valid && fifo_out_ready) begin
        mask_q[fifo_out_data[FIFO_W-1:BYTE_W]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SDA_O = 1'b0;
  assign SDA_OE_N = sda_oe_n_q;
  assign BUSY = busy_q;
  assign STANDBY = (state_q == ST_IDLE) & ~busy_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK iff CE);
  endclocking
  default disable iff (RST);

  sequence seq_dev_done;
    rx_done && role_q == ROLE_DEV;
  endsequence

  sequence seq_data_done;
    data_take;
  endsequence

  AST_DEV_ACK:
    assert property (seq_dev_done ##0 dev_match |=> state_q == ST_ACK && !sda_oe_n_q)
    else $error("matching select word not acknowledged");
  AST_DEV_NACK:
    assert property (seq_dev_done ##0 !dev_match |=> state_q == ST_IDLE && sda_oe_n_q)
    else $error("mismatching select word acknowledged");
  AST_START:
    assert property (start_evt && !busy_q |=> state_q == ST_RX && bitcnt_q == 4'h0
                     && role_q == ROLE_DEV)
    else $error("start did not open a select word");
  AST_STOP:
    assert property (stop_evt |=> state_q == ST_IDLE && sda_oe_n_q)
    else $error("stop did not return to idle");
  AST_OE_ON_FALL:
    assert property ($changed(sda_oe_n_q) |-> $past(scl_fall || start_evt || stop_evt))
    else $error("data line changed away from clock fall");
  AST_BUSY_QUIET:
    assert property (busy_q |-> state_q == ST_IDLE && sda_oe_n_q)
    else $error("bus answered during program cycle");
  AST_PROG_LEN:
    assert property ($fell(busy_q) |-> $past(pcnt_q) == PCW'(PROG_CYCLES - 1))
    else $error("program cycle length wrong");
  AST_WP_BLOCK:
    assert property (stop_evt && !busy_q && wp_s |=> !busy_q)
    else $error("program started while protected");
  AST_PAGE_WRAP:
    assert property (seq_data_done |=> wptr_q[11:5] == $past(wptr_q[11:5])
                     && wptr_q[4:0] == $past(wptr_q[4:0]) + 5'h01)
    else $error("write pointer left its page");
  AST_READ_INC:
    assert property (load_rd |=> ctr_q == $past(ctr_q) + 12'h001)
    else $error("read counter did not advance");

  sequence seq_prog_go;
    stop_evt && !busy_q && pending_q && !wp_s;
  endsequence

  AST_PROG_START:
    assert property (seq_prog_go |=> busy_q && pcnt_q == '0)
    else $error("stop did not start the program cycle");
  AST_READ_LOAD:
    assert property (load_rd |=> state_q == ST_TX && bitcnt_q == 4'h0)
    else $error("read byte not loaded for shifting");
endmodule : i2c_serial_eeprom_slave

// [tb/bus_master_model.sv]
// Two-wire bus master model with open-drain data and pull-up
`timescale 1ns/100ps
module bus_master_model (
  input wire logic MCLK,
  input wire logic SDA_OE_N,
  output logic SCL,
  output logic SDA_I
);
  logic sda_drv_n;
  // ----------------------------------------------------------------
  // Wire level: pull-up, either party pulls low
  // ----------------------------------------------------------------
  assign SDA_I = (SDA_OE_N === 1'b0) ? 1'b0 : sda_drv_n;
  initial begin
    SCL = 1'b1;
    sda_drv_n = 1'b1;
  end
  // ----------------------------------------------------------------
  // Bus primitives
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask : tick
  task automatic clk_bit(input logic tx, output logic rx);
    tick(2);
    sda_drv_n <= tx;
    tick(2);
    SCL <= 1'b1;
    tick(2);
    rx = SDA_I;
    tick(2);
    SCL <= 1'b0;
  endtask : clk_bit
  task automatic start_cond();
    tick(2);
    sda_drv_n <= 1'b1;
    tick(2);
    SCL <= 1'b1;
    tick(2);
    sda_drv_n <= 1'b0;
    tick(2);
    SCL <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    tick(2);
    sda_drv_n <= 1'b0;
    tick(2);
    SCL <= 1'b1;
    tick(2);
    sda_drv_n <= 1'b1;
    tick(2);
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], r);
    end
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b, input bit more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(~more, r);
  endtask : get_byte
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      clk_bit(1'b1, r);
      if (r === 1'b1) break;
    end
    start_cond();
  endtask : recover
endmodule : bus_master_model

// [tb/testbench.sv]
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
module testbench;
  import eeprom_pkg::*;
  localparam int PROG = 64;
  logic mclk, rst, wp, scl, sda_i, sda_o, sda_oe_n, busy, standby, a;
  logic [STRAP_W-1:0] straps;
  logic [7:0] rd;
  logic [7:0] bad_sel [2];
  int err_count = 0;
  int cmp_count = 0;
  i2c_serial_eeprom_slave #(.PROG_CYCLES(PROG), .FIFO_DEPTH(FIFO_DEPTH)) dut_u (
    .MCLK(mclk), .RST(rst), .CE(1'b1), .SCL(scl), .SDA_I(sda_i), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n), .WP(wp), .CHIP_SELECT_STRAPS(straps), .BUSY(busy),
    .STANDBY(standby));
  bus_master_model mst_u (.MCLK(mclk), .SDA_OE_N(sda_oe_n), .SCL(scl), .SDA_I(sda_i));
  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic select(input logic rw, output logic ack);
    mst_u.start_cond();
    mst_u.put_byte({DEV_TYPE_CODE, straps, rw}, ack);
  endtask : select
  task automatic address(input logic [11:0] ad);
    select(1'b0, a);
    chk_bit("select ack", 1'b1, a);
    mst_u.put_byte({4'h0, ad[11:8]}, a);
    chk_bit("addr hi ack", 1'b1, a);
    mst_u.put_byte(ad[7:0], a);
    chk_bit("addr lo ack", 1'b1, a);
  endtask : address
  task automatic write_bytes(input logic [11:0] ad, input logic [7:0] d[$]);
    address(ad);
    foreach (d[i]) begin
      mst_u.put_byte(d[i], a);
      chk_bit("data ack", 1'b1, a);
    end
    mst_u.stop_cond();
  endtask : write_bytes
  task automatic read_bytes(input logic [11:0] ad, input bit cur, input logic [7:0] e[$]);
    if (!cur) address(ad);
    select(1'b1, a);
    chk_bit("read select ack", 1'b1, a);
    foreach (e[i]) begin
      mst_u.get_byte(rd, i < e.size() - 1);
      chk_byte("read data", e[i], rd);
    end
    mst_u.stop_cond();
  endtask : read_bytes
  task automatic wait_done(input logic busy_exp);
    int n;
    n = 0;
    a = 1'b0;
    mst_u.tick(4);
    chk_bit("busy", busy_exp, busy);
    while (a !== 1'b1 && n < 50) begin
      select(1'b0, a);
      if (n == 0) chk_bit("first poll ack", ~busy_exp, a);
      mst_u.stop_cond();
      n++;
    end
    mst_u.tick(4);
    chk_bit("standby", 1'b1, standby);
  endtask : wait_done
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #3_000_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    straps = 3'b101;
    bad_sel = '{8'hBA, 8'hAC};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_bit("standby", 1'b1, standby);
    chk_bit("sda drive level", 1'b0, sda_o);
    mst_u.recover();
    mst_u.stop_cond();
    write_bytes(12'h123, {8'h5A});
    wait_done(1'b1);
    read_bytes(12'h123, 1'b0, {8'h5A});
    $display("test byte write done");
    write_bytes(12'h03E, {8'h11, 8'h22, 8'h33, 8'h44});
    wait_done(1'b1);
    read_bytes(12'h03E, 1'b0, {8'h11, 8'h22});
    read_bytes(12'h020, 1'b0, {8'h33});
    read_bytes(12'h000, 1'b1, {8'h44});
    $display("test page wrap done");
    write_bytes(12'hFFF, {8'hA5});
    wait_done(1'b1);
    write_bytes(12'h000, {8'h5C});
    wait_done(1'b1);
    read_bytes(12'hFFF, 1'b0, {8'hA5, 8'h5C});
    $display("test array wrap done");
    foreach (bad_sel[i]) begin
      mst_u.start_cond();
      mst_u.put_byte(bad_sel[i], a);
      chk_bit("bad select nack", 1'b0, a);
      mst_u.stop_cond();
    end
    $display("test select mismatch done");
    wp <= 1'b1;
    write_bytes(12'h123, {8'hC3});
    wait_done(1'b0);
    wp <= 1'b0;
    read_bytes(12'h123, 1'b0, {8'h5A});
    $display("test write protect done");
    tally_and_finish();
  end
endmodule : testbench
